// File: shared/crm_defines.svh
/*
  Constants for the receive match and shift-in block: sizes, mailbox state
  codes, filter bit positions, FIFO limits and transfer timing.
  Assumes it is included by bare name before the package and the modules.
*/
`ifndef CRM_DEFINES_SVH
`define CRM_DEFINES_SVH

`define CRM_N_MB 16
`define CRM_MB_IW 4
`define CRM_N_FELEM 8
`define CRM_FE_IW 3
`define CRM_N_IMASK 32

`define CRM_FIFO_DEPTH 3'h6
`define CRM_FIFO_WARN_FROM 3'h4

`define CRM_CODE_INACTIVE 4'h0
`define CRM_CODE_FULL 4'h2
`define CRM_CODE_EMPTY 4'h4
`define CRM_CODE_OVERRUN 4'h6
`define CRM_CODE_REMOTE_ANSWER_CODE 4'ha
`define CRM_BUSY_BIT 0

`define CRM_ID_MSB 28
`define CRM_IDE_BIT 30
`define CRM_RTR_BIT 31

`define CRM_FMT_IDONLY 2'h2
`define CRM_FMT_REJECT 2'h3

`define CRM_XFER_CYCLES 2'h2

`endif

// File: shared/crm_pkg.sv
/*
  Types for the receive match and shift-in block.
  Assumes crm_defines.svh is on the include path.
*/
`include "crm_defines.svh"
`default_nettype none

package crm_pkg;
  typedef logic [31:0] crm_word_t;
  typedef logic [3:0] crm_code_t;

  typedef enum logic [1:0] {
    CRM_CMP_NEVER = 2'h0,
    CRM_CMP_ALWAYS = 2'h1,
    CRM_CMP_FILT = 2'h2
  } crm_cmp_t;

  typedef enum logic [1:0] {
    CRM_IDLE = 2'h0,
    CRM_SEARCH = 2'h1,
    CRM_PEND = 2'h3,
    CRM_XFER = 2'h2
  } crm_state_t;

  typedef struct packed {
    logic [`CRM_ID_MSB:0] id;
    logic ide;
    logic rtr;
    logic self_sent;
    logic [3:0] dlc;
    logic [63:0] data;
  } crm_frame_t;

  typedef struct packed {
    logic fifo_en;
    logic search_order_sel;
    logic private_mask_queue_en;
    logic remote_store_sel;
    logic idertr_mask_sel;
    logic [1:0] fifo_filter_format;
    logic self_rx_disable;
    logic low_power_state;
    logic inactive_mode;
    logic [3:0] fifo_filter_count;
  } crm_cfg_t;

  typedef struct packed {
    logic hdr_done;
    logic ifs_bit1;
    logic ifs_bit2;
    logic overload_bit1;
    logic protocol_error;
  } crm_evt_t;

  typedef struct packed {
    logic valid;
    logic fifo;
    logic [`CRM_MB_IW-1:0] index;
    crm_code_t code;
    logic [`CRM_FE_IW-1:0] fifo_match_info;
    crm_frame_t frame;
  } crm_store_t;
endpackage : crm_pkg

`default_nettype wire

// File: verilog/crm_id_cmp.sv
/*
  One acceptance comparator: received identifier word against one filter
  element or mailbox word, under a mask and per-field compare modes.
  Word layout: id in 28:0, IDE in 30, RTR in 31; bit 29 is never compared.
*/
`timescale 1ns/10ps
`default_nettype none
`include "crm_defines.svh"

module crm_id_cmp (
  input wire crm_pkg::crm_word_t rx_in,
  input wire crm_pkg::crm_word_t desc_in,
  input wire crm_pkg::crm_word_t mask_in,
  input wire crm_pkg::crm_cmp_t ide_mode_in,
  input wire crm_pkg::crm_cmp_t rtr_mode_in,
  output logic hit_out
);
  import crm_pkg::*;

  function automatic logic field_ok(input crm_cmp_t mode, input logic a, input logic b,
                                    input logic m);
    logic ok;
    case (mode)
      CRM_CMP_ALWAYS: ok = (a == b);
      CRM_CMP_FILT: ok = (a == b) || !m;
      default: ok = 1'b1;
    endcase
    return ok;
  endfunction : field_ok

  crm_word_t diff;

  always_comb begin
    diff = (rx_in ^ desc_in) & mask_in;
    hit_out = (diff[`CRM_ID_MSB:0] == '0)
      && field_ok(ide_mode_in, rx_in[`CRM_IDE_BIT], desc_in[`CRM_IDE_BIT],
                  mask_in[`CRM_IDE_BIT])
      && field_ok(rtr_mode_in, rx_in[`CRM_RTR_BIT], desc_in[`CRM_RTR_BIT],
                  mask_in[`CRM_RTR_BIT]);
  end
endmodule : crm_id_cmp

`default_nettype wire

// File: verilog/crm_pick.sv
/*
  Priority picker: whether any bit is set, the lowest set index and the
  highest set index. Purely combinational.
*/
`timescale 1ns/10ps
`default_nettype none

module crm_pick #(
  parameter int unsigned N = 16,
  parameter int unsigned W = 4
) (
  input wire logic [N-1:0] vec_in,
  output logic any_out,
  output logic [W-1:0] first_out,
  output logic [W-1:0] last_out
);
  always_comb begin
    any_out = |vec_in;
    first_out = '0;
    last_out = '0;
    for (int i = N - 1; i >= 0; i--) begin
      if (vec_in[i]) begin
        first_out = W'(i);
      end
    end
    for (int j = 0; j < N; j++) begin
      if (vec_in[j]) begin
        last_out = W'(j);
      end
    end
  end
endmodule : crm_pick

`default_nettype wire

// File: verilog/crm_shiftin.sv
/*
  Receive acceptance search, winner choice, shift-in transfer and FIFO
  warning / overflow flags of a CAN controller.
  Assumes the protocol engine on the same clock supplies the shift buffer,
  bus-position pulses, and that mailbox state and masks come from the
  message RAM logic, which applies the store_out writes.
*/
`timescale 1ns/10ps
`default_nettype none
`include "crm_defines.svh"

module crm_shiftin (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire crm_pkg::crm_cfg_t cfg_in,
  input wire crm_pkg::crm_evt_t evt_in,
  input wire crm_pkg::crm_frame_t frame_in,
  input wire crm_pkg::crm_code_t mb_code_in [`CRM_N_MB],
  input wire crm_pkg::crm_word_t mb_word_in [`CRM_N_MB],
  input wire logic [`CRM_N_MB-1:0] mb_serviced_in,
  input wire logic [`CRM_N_MB-1:0] mb_locked_in,
  input wire crm_pkg::crm_word_t fifo_filter_in [`CRM_N_FELEM],
  input wire crm_pkg::crm_word_t shared_mailbox_mask_in,
  input wire crm_pkg::crm_word_t shared_fifo_mask_in,
  input wire crm_pkg::crm_word_t individual_mask_n_in [`CRM_N_IMASK],
  input wire logic fifo_pop_in,
  input wire logic warn_clr_in,
  input wire logic overflow_clr_in,
  output var crm_pkg::crm_store_t store_out,
  output logic [`CRM_N_MB-1:0] mb_busy_out,
  output logic [2:0] fifo_count_out,
  output logic fifo_warn_flag_out,
  output logic fifo_overflow_flag_out
);
  import crm_pkg::*;

  // ----------------------------------------
  // state
  // ----------------------------------------
  crm_state_t state_q, state_d;
  crm_frame_t hdr_q, hdr_d;
  logic win_fifo_q, win_fifo_d;
  logic [`CRM_MB_IW-1:0] win_idx_q, win_idx_d;
  logic win_ovr_q, win_ovr_d;
  logic [`CRM_FE_IW-1:0] win_elem_q, win_elem_d;
  logic ifs_seen_q, ifs_seen_d;
  logic [1:0] xcnt_q, xcnt_d;
  crm_store_t store_q, store_d;
  logic [2:0] cnt_q, cnt_d;
  logic warn_q, warn_d;
  logic ovf_q, ovf_d;

  // ----------------------------------------
  // comparators
  // ----------------------------------------
  crm_word_t rx_word;
  logic remote_only;
  crm_cmp_t mb_ide_mode, mb_rtr_mode, fe_ide_mode, fe_rtr_mode;
  logic [`CRM_N_MB-1:0] mb_cmp, mb_elig, mb_free, mb_hit;
  logic [`CRM_N_FELEM-1:0] fe_cmp;

  assign rx_word = {hdr_q.rtr, hdr_q.ide, 1'b0, hdr_q.id};
  assign remote_only = hdr_q.rtr && !cfg_in.remote_store_sel;

  always_comb begin
    if (remote_only) begin
      mb_ide_mode = CRM_CMP_FILT;
      mb_rtr_mode = CRM_CMP_NEVER;
    end else if (!cfg_in.idertr_mask_sel) begin
      mb_ide_mode = CRM_CMP_ALWAYS;
      mb_rtr_mode = CRM_CMP_NEVER;
    end else begin
      mb_ide_mode = CRM_CMP_FILT;
      mb_rtr_mode = CRM_CMP_FILT;
    end
    if (cfg_in.fifo_filter_format == `CRM_FMT_IDONLY) begin
      fe_ide_mode = CRM_CMP_NEVER;
      fe_rtr_mode = CRM_CMP_NEVER;
    end else begin
      fe_ide_mode = CRM_CMP_FILT;
      fe_rtr_mode = CRM_CMP_FILT;
    end
  end

  for (genvar i = 0; i < `CRM_N_MB; i++) begin : g_mb
    crm_word_t mask;
    logic full_like;
    // per-box mask only in queue mode, shared otherwise
    assign mask = cfg_in.private_mask_queue_en ? individual_mask_n_in[i]
                                               : shared_mailbox_mask_in;
    assign full_like = (mb_code_in[i] == `CRM_CODE_FULL)
                    || (mb_code_in[i] == `CRM_CODE_OVERRUN);
    assign mb_elig[i] = remote_only ? (mb_code_in[i] == `CRM_CODE_REMOTE_ANSWER_CODE)
                      : ((mb_code_in[i] == `CRM_CODE_EMPTY) || full_like);
    assign mb_free[i] = remote_only || (mb_code_in[i] == `CRM_CODE_EMPTY)
                      || (full_like && mb_serviced_in[i] && !mb_locked_in[i]);
    assign mb_hit[i] = mb_elig[i] && mb_cmp[i];
    crm_id_cmp u_cmp (
      .rx_in(rx_word),
      .desc_in(mb_word_in[i]),
      .mask_in(mask),
      .ide_mode_in(mb_ide_mode),
      .rtr_mode_in(mb_rtr_mode),
      .hit_out(mb_cmp[i])
    );
  end

  for (genvar k = 0; k < `CRM_N_FELEM; k++) begin : g_fe
    crm_word_t mask;
    // configured elements take individual masks in queue mode
    assign mask = (cfg_in.private_mask_queue_en && (4'(k) <= cfg_in.fifo_filter_count))
                ? individual_mask_n_in[k] : shared_fifo_mask_in;
    crm_id_cmp u_cmp (
      .rx_in(rx_word),
      .desc_in(fifo_filter_in[k]),
      .mask_in(mask),
      .ide_mode_in(fe_ide_mode),
      .rtr_mode_in(fe_rtr_mode),
      .hit_out(fe_cmp[k])
    );
  end

  // ----------------------------------------
  // winner choice
  // ----------------------------------------
  logic any_hit, any_free, any_nonfree, any_fe;
  logic [`CRM_MB_IW-1:0] first_hit, first_free, last_nonfree;
  logic [`CRM_FE_IW-1:0] first_fe;
  logic fifo_hit, fifo_full, fifo_ok;
  logic sel_valid, sel_fifo, sel_ovr, mb_ovr, ovf_evt;
  logic [`CRM_MB_IW-1:0] sel_idx, mb_idx;

  crm_pick #(.N(`CRM_N_MB), .W(`CRM_MB_IW)) u_pick_hit (
    .vec_in(mb_hit), .any_out(any_hit), .first_out(first_hit), .last_out()
  );
  crm_pick #(.N(`CRM_N_MB), .W(`CRM_MB_IW)) u_pick_free (
    .vec_in(mb_hit & mb_free), .any_out(any_free), .first_out(first_free), .last_out()
  );
  crm_pick #(.N(`CRM_N_MB), .W(`CRM_MB_IW)) u_pick_busy (
    .vec_in(mb_hit & ~mb_free), .any_out(any_nonfree), .first_out(),
    .last_out(last_nonfree)
  );
  crm_pick #(.N(`CRM_N_FELEM), .W(`CRM_FE_IW)) u_pick_fe (
    .vec_in(fe_cmp), .any_out(any_fe), .first_out(first_fe), .last_out()
  );

  assign fifo_hit = cfg_in.fifo_en && any_fe
                 && (cfg_in.fifo_filter_format != `CRM_FMT_REJECT);
  assign fifo_full = (cnt_q == `CRM_FIFO_DEPTH);
  assign fifo_ok = fifo_hit && !fifo_full;

  always_comb begin
    if (cfg_in.private_mask_queue_en) begin
      mb_idx = any_free ? first_free : last_nonfree;
      mb_ovr = !any_free;
    end else begin
      mb_idx = first_hit;
      mb_ovr = !mb_free[first_hit];
    end
    sel_valid = 1'b1;
    sel_fifo = 1'b0;
    sel_idx = mb_idx;
    sel_ovr = mb_ovr;
    ovf_evt = 1'b0;
    if (!cfg_in.search_order_sel && fifo_ok) begin
      sel_fifo = 1'b1;
    end else if (cfg_in.private_mask_queue_en && !any_free && any_nonfree && fifo_ok) begin
      sel_fifo = 1'b1;
    end else if (any_hit) begin
      sel_fifo = 1'b0;
    end else if (fifo_ok) begin
      sel_fifo = 1'b1;
    end else begin
      sel_valid = 1'b0;
      ovf_evt = fifo_hit;
    end
  end

  // ----------------------------------------
  // search, pending and transfer sequencer
  // ----------------------------------------
  logic start_ok, cancel;

  always_comb begin
    start_ok = !cfg_in.low_power_state
            && (evt_in.ifs_bit2 || evt_in.overload_bit1 || cfg_in.inactive_mode)
            && (win_fifo_q || !mb_locked_in[win_idx_q]);
    cancel = !win_fifo_q
          && ((ifs_seen_q && (mb_code_in[win_idx_q] == `CRM_CODE_INACTIVE))
          || (hdr_q.self_sent && cfg_in.self_rx_disable)
          || evt_in.protocol_error);
    state_d = state_q;
    hdr_d = hdr_q;
    win_fifo_d = win_fifo_q;
    win_idx_d = win_idx_q;
    win_ovr_d = win_ovr_q;
    win_elem_d = win_elem_q;
    ifs_seen_d = ifs_seen_q;
    xcnt_d = xcnt_q;
    store_d = store_q;
    store_d.valid = 1'b0;
    case (state_q)
      CRM_SEARCH: begin
        win_fifo_d = sel_fifo;
        win_idx_d = sel_idx;
        win_ovr_d = sel_ovr;
        win_elem_d = first_fe;
        state_d = sel_valid ? CRM_PEND : CRM_IDLE;
      end
      CRM_PEND: begin
        ifs_seen_d = ifs_seen_q || evt_in.ifs_bit1;
        if (cancel) begin
          state_d = CRM_IDLE;
        end else if (start_ok) begin
          state_d = CRM_XFER;
          xcnt_d = `CRM_XFER_CYCLES - 2'h1;
        end
      end
      CRM_XFER: begin
        if (xcnt_q == 2'h0) begin
          state_d = CRM_IDLE;
          store_d.valid = 1'b1;
          store_d.fifo = win_fifo_q;
          store_d.index = win_idx_q;
          store_d.code = win_ovr_q ? `CRM_CODE_OVERRUN : `CRM_CODE_FULL;
          store_d.fifo_match_info = win_elem_q;
          store_d.frame = frame_in;
        end else begin
          xcnt_d = xcnt_q - 2'h1;
        end
      end
      default: begin
      end
    endcase
    // a new header outside the transfer state reloads the held header and restarts the search
    if (evt_in.hdr_done && (state_q != CRM_XFER)) begin
      state_d = CRM_SEARCH;
      hdr_d = frame_in;
      ifs_seen_d = 1'b0;
    end
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      state_q <= CRM_IDLE;
      hdr_q <= '0;
      win_fifo_q <= 1'b0;
      win_idx_q <= '0;
      win_ovr_q <= 1'b0;
      win_elem_q <= '0;
      ifs_seen_q <= 1'b0;
      xcnt_q <= 2'h0;
      store_q <= '0;
    end else begin
      state_q <= state_d;
      hdr_q <= hdr_d;
      win_fifo_q <= win_fifo_d;
      win_idx_q <= win_idx_d;
      win_ovr_q <= win_ovr_d;
      win_elem_q <= win_elem_d;
      ifs_seen_q <= ifs_seen_d;
      xcnt_q <= xcnt_d;
      store_q <= store_d;
    end
  end

  always_comb begin
    mb_busy_out = '0;
    if ((state_q == CRM_XFER) && !win_fifo_q) begin
      mb_busy_out[win_idx_q] = 1'b1;
    end
  end

  // ----------------------------------------
  // FIFO occupancy and flags
  // ----------------------------------------
  logic push, pop;

  assign push = store_d.valid && store_d.fifo;
  assign pop = fifo_pop_in && (cnt_q != 3'h0);

  always_comb begin
    cnt_d = cnt_q + 3'(push) - 3'(pop);
    // set wins over a clear in the same cycle
    warn_d = (warn_q && !warn_clr_in)
          || (push && !pop && (cnt_q == `CRM_FIFO_WARN_FROM));
    ovf_d = (ovf_q && !overflow_clr_in) || ((state_q == CRM_SEARCH) && ovf_evt);
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      cnt_q <= 3'h0;
      warn_q <= 1'b0;
      ovf_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      warn_q <= warn_d;
      ovf_q <= ovf_d;
    end
  end

  assign store_out = store_q;
  assign fifo_count_out = cnt_q;
  assign fifo_warn_flag_out = warn_q;
  assign fifo_overflow_flag_out = ovf_q;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (reset_in);

  a_warn_at_five: assert property (
    (push && !pop && cnt_q == 3'h4) |=> (fifo_warn_flag_out && fifo_count_out == 3'h5))
    else $error("warn flag missing on fifth message");
  a_overflow_set: assert property (
    (state_q == CRM_SEARCH && fifo_hit && fifo_full && !any_hit) |=> fifo_overflow_flag_out)
    else $error("overflow flag missing");
  a_search_start: assert property (
    (evt_in.hdr_done && state_q != CRM_XFER) |=> (state_q == CRM_SEARCH))
    else $error("search did not start after header");
  a_fifo_first: assert property (
    (state_q == CRM_SEARCH && !cfg_in.search_order_sel && fifo_ok && !evt_in.hdr_done)
    |=> (state_q == CRM_PEND && win_fifo_q))
    else $error("fifo did not win in fifo-first order");
  a_reject_fmt: assert property (
    (cfg_in.fifo_filter_format == 2'h3) |-> !fifo_hit)
    else $error("fifo matched in reject format");
  a_start_gate: assert property (
    (state_q == CRM_PEND && !start_ok && !evt_in.hdr_done) |=> state_q != CRM_XFER)
    else $error("transfer started without its conditions");
  a_busy_hold: assert property (
    (state_q == CRM_PEND ##1 state_q == CRM_XFER && !win_fifo_q)
    |-> mb_busy_out[win_idx_q] [*2])
    else $error("busy bit not held during transfer");
  a_cancel_err: assert property (
    (state_q == CRM_PEND && !win_fifo_q && evt_in.protocol_error && !evt_in.hdr_done)
    |=> state_q == CRM_IDLE ##1 !store_out.valid)
    else $error("mailbox transfer not cancelled");
  a_store_done: assert property (
    (state_q == CRM_PEND ##1 state_q == CRM_XFER) |-> ##2 store_out.valid)
    else $error("store missing after transfer");

  c_fifo_store: cover property (store_out.valid && store_out.fifo);
  c_overrun: cover property (store_out.valid && store_out.code == `CRM_CODE_OVERRUN);
  c_overflow: cover property ($rose(fifo_overflow_flag_out));
  c_cancel: cover property (state_q == CRM_PEND && cancel);
endmodule : crm_shiftin

`default_nettype wire

// File: dv/crm_bus_node.sv
/*
  Bus-side stand-in for the protocol engine: shift buffer plus position pulses.
  Assumes the bench raises start_in for one cycle for each frame it wants sent.
*/
`timescale 1ns/10ps
`default_nettype none

module crm_bus_node (
  input wire logic clk_in,
  input wire logic start_in,
  input wire logic ovl_in,
  input wire logic err_in,
  input wire crm_pkg::crm_frame_t tx_in,
  output var crm_pkg::crm_evt_t evt_out,
  output var crm_pkg::crm_frame_t frame_out
);
  import crm_pkg::*;
  logic [1:0] step_q = 2'h0;

  // position pulse three cycles after the header, never closer than two
  // error lands while the transfer is pending, so it can cancel it
  always @(negedge clk_in) begin
    crm_evt_t nxt;
    nxt = '0;
    if (start_in) begin
      step_q <= 2'h1;
      frame_out <= tx_in;
      nxt.hdr_done = 1'b1;
    end else if (step_q != 2'h0) begin
      step_q <= step_q + 2'h1;
      nxt.protocol_error = err_in && (step_q == 2'h2);
      nxt.ifs_bit1 = (step_q == 2'h2);
      nxt.ifs_bit2 = (step_q == 2'h3) && !ovl_in;
      nxt.overload_bit1 = (step_q == 2'h3) && ovl_in;
    end
    evt_out <= nxt;
  end
endmodule : crm_bus_node

`default_nettype wire

// File: dv/testbench.sv
/*
  Self-checking bench for crm_shiftin: random frames against random mailbox
  and FIFO setups, plus a lock and low-power corner.
  Assumes crm_bus_node plays the bus and all masks hold one common value.
*/
`timescale 1ns/10ps
`default_nettype none
`include "crm_defines.svh"

module testbench;
  import crm_pkg::*;
  logic clk = 1'b0;
  logic rst, start, ovl, err, pop, wclr, oclr, seen, bseen, ewarn, eovf;
  crm_cfg_t cfg;
  crm_evt_t evt;
  crm_frame_t frm, tx;
  crm_store_t st, got;
  crm_code_t codes [16];
  crm_word_t words [16];
  crm_word_t filt [8];
  crm_word_t imask [32];
  crm_word_t msk = 32'hffffffff;
  crm_code_t kinds [5] = '{`CRM_CODE_INACTIVE, `CRM_CODE_FULL, `CRM_CODE_EMPTY,
                           `CRM_CODE_OVERRUN, `CRM_CODE_REMOTE_ANSWER_CODE};
  logic [15:0] serv, lock, busy;
  logic [2:0] cnt_o;
  logic warn_o, ovf_o;
  int mismatches, checked, cyc, ecnt;

  initial forever #20 clk = ~clk;

  crm_bus_node u_node (.clk_in(clk), .start_in(start), .ovl_in(ovl), .err_in(err),
    .tx_in(tx), .evt_out(evt), .frame_out(frm));

  crm_shiftin u_dut (.clk_in(clk), .reset_in(rst), .cfg_in(cfg), .evt_in(evt),
    .frame_in(frm), .mb_code_in(codes), .mb_word_in(words), .mb_serviced_in(serv),
    .mb_locked_in(lock), .fifo_filter_in(filt), .shared_mailbox_mask_in(msk),
    .shared_fifo_mask_in(msk), .individual_mask_n_in(imask), .fifo_pop_in(pop),
    .warn_clr_in(wclr), .overflow_clr_in(oclr), .store_out(st), .mb_busy_out(busy),
    .fifo_count_out(cnt_o), .fifo_warn_flag_out(warn_o), .fifo_overflow_flag_out(ovf_o));

  // ------------------------------------------------------------
  // checking helpers
  // ------------------------------------------------------------
  task automatic chk(input logic [127:0] g, input logic [127:0] e, input string what);
    checked++;
    if (g !== e) begin
      mismatches++;
      $display("MISMATCH t=%0t %s got %0h exp %0h", $time, what, g, e);
    end
  endtask : chk

  task wrap_up;
    $display("compares %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : wrap_up

  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      mismatches++;
      wrap_up;
    end
  end

  // winner as {valid, fifo, overrun, index}
  function automatic logic [6:0] expect_win(logic [15:0] mm, logic [15:0] ff, logic fh,
                                            logic full);
    int first, ffree, last;
    logic fok;
    first = -1;
    ffree = -1;
    last = -1;
    fok = cfg.fifo_en && fh && !full;
    for (int i = 15; i >= 0; i--) begin
      if (mm[i]) first = i;
      if (mm[i] && ff[i]) ffree = i;
      if (last < 0 && mm[i] && !ff[i]) last = i;
    end
    if (fok && !cfg.search_order_sel) return 7'h60;
    if (first >= 0 && !cfg.private_mask_queue_en) return {2'b10, !ff[first], 4'(first)};
    if (ffree >= 0) return {3'b100, 4'(ffree)};
    if (fok) return 7'h60;
    if (last >= 0) return {3'b101, 4'(last)};
    return 7'h00;
  endfunction : expect_win

  // ------------------------------------------------------------
  // stimulus
  // ------------------------------------------------------------
  task automatic watch(input int idx, input int n);
    seen = 0;
    bseen = 0;
    repeat (n) begin
      @(negedge clk);
      if (st.valid === 1'b1) begin
        seen = 1;
        got = st;
      end
      if (busy === 16'h1 << idx) bseen = 1;
    end
  endtask : watch

  task automatic send(input int idx, input int n);
    @(negedge clk);
    start <= 1'b1;
    @(negedge clk);
    start <= 1'b0;
    watch(idx, n);
  endtask : send

  task automatic run_frame(input int dens);
    logic [15:0] mm, ff;
    logic fh, full, drop, rmt;
    logic [6:0] w;
    int k;
    cfg = crm_cfg_t'(14'($urandom));
    cfg.low_power_state = 1'b0;
    cfg.inactive_mode = 1'b0;
    tx.id = 29'($urandom);
    tx.ide = 1'($urandom);
    tx.rtr = 1'($urandom);
    rmt = tx.rtr && !cfg.remote_store_sel;
    tx.dlc = 4'($urandom);
    tx.data = {$urandom, $urandom};
    tx.self_sent = (ecnt < 6) && ($urandom % 4 == 0);
    k = $urandom % 8;
    fh = ($urandom % 4 != 0);
    for (int i = 0; i < 16; i++) begin
      codes[i] = kinds[$urandom % 5];
      serv[i] = 1'($urandom);
      mm[i] = (($urandom % 8) < dens);
      words[i] = {tx.rtr, tx.ide, 1'b0, mm[i] ? tx.id : ~tx.id};
      mm[i] = mm[i] && (rmt ? codes[i] == `CRM_CODE_REMOTE_ANSWER_CODE
              : codes[i] inside {`CRM_CODE_EMPTY, `CRM_CODE_FULL, `CRM_CODE_OVERRUN});
      ff[i] = rmt || codes[i] == `CRM_CODE_EMPTY
              || (codes[i] != `CRM_CODE_INACTIVE && serv[i]);
    end
    for (int j = 0; j < 8; j++)
      filt[j] = {tx.rtr, 1'($urandom), 1'b0, (j == k && fh) ? tx.id : ~tx.id};
    fh = fh && cfg.fifo_filter_format != `CRM_FMT_REJECT;
    fh = fh && (cfg.fifo_filter_format == `CRM_FMT_IDONLY || filt[k][30] == tx.ide);
    full = (ecnt == 6);
    w = expect_win(mm, ff, fh, full);
    ovl <= 1'($urandom);
    err <= ($urandom % 16 == 0);
    #1;
    drop = (err || (tx.self_sent && cfg.self_rx_disable)) && !w[5];
    send(w[3:0], 12);
    chk(seen, w[6] && !drop, "store");
    if (seen) begin
      chk(got.fifo, w[5], "target");
      chk(got.frame, tx, "frame");
      if (w[5]) chk(got.fifo_match_info, k, "match info");
      else begin
        chk(got.index, w[3:0], "mailbox");
        chk(got.code, w[4] ? `CRM_CODE_OVERRUN : `CRM_CODE_FULL, "code");
        chk(bseen, 1'b1, "busy");
      end
    end
    if (w[6] && w[5]) begin
      ewarn |= (ecnt == 4);
      ecnt++;
    end
    eovf |= cfg.fifo_en && fh && full && !w[6];
    chk(cnt_o, ecnt, "count");
    chk(warn_o, ewarn, "warn");
    chk(ovf_o, eovf, "overflow");
    pop = ($urandom % 3 == 0);
    wclr = ($urandom % 8 == 0);
    oclr = ($urandom % 8 == 0);
    if (pop && ecnt > 0) ecnt--;
    if (wclr) ewarn = 0;
    if (oclr) eovf = 0;
    @(negedge clk);
    pop = 0;
    wclr = 0;
    oclr = 0;
  endtask : run_frame

  // locked target waits; low power holds the unlock; deactivation cancels
  task automatic lock_case;
    cfg = '0;
    cfg.search_order_sel = 1'b1;
    err <= 1'b0;
    tx.rtr = 1'b0;
    for (int i = 0; i < 16; i++) codes[i] = `CRM_CODE_INACTIVE;
    codes[2] = `CRM_CODE_FULL;
    words[2] = {1'b0, tx.ide, 1'b0, tx.id};
    serv[2] = 1'b1;
    lock = 16'h0004;
    send(2, 12);
    chk(seen, 1'b0, "locked");
    cfg.low_power_state = 1'b1;
    cfg.inactive_mode = 1'b1;
    lock = 16'h0;
    watch(2, 8);
    chk(seen, 1'b0, "low power");
    cfg.low_power_state = 1'b0;
    watch(2, 8);
    chk(seen, 1'b1, "inactive");
    chk(got.code, `CRM_CODE_OVERRUN, "locked code");
    chk(got.index, 4'h2, "locked index");
    chk(bseen, 1'b1, "locked busy");
    lock = 16'h0004;
    send(2, 12);
    codes[2] = `CRM_CODE_INACTIVE;
    lock = 16'h0;
    watch(2, 8);
    chk(seen, 1'b0, "deactivated");
    cfg.inactive_mode = 1'b0;
  endtask : lock_case

  initial begin
    void'($urandom(32'hd263));
    rst = 1'b1;
    {start, ovl, err, pop, wclr, oclr, ewarn, eovf} = '0;
    cfg = '0;
    tx = '0;
    serv = '0;
    lock = '0;
    for (int i = 0; i < 16; i++) codes[i] = `CRM_CODE_INACTIVE;
    for (int i = 0; i < 16; i++) words[i] = '0;
    for (int j = 0; j < 8; j++) filt[j] = '0;
    for (int m = 0; m < 32; m++) imask[m] = msk;
    repeat (10) @(negedge clk);
    rst = 1'b0;
    chk(st, 0, "reset store");
    chk({busy, cnt_o, warn_o, ovf_o}, 0, "reset flags");
    for (int t = 0; t < 300; t++) run_frame(t % 5);
    $display("test random frames done");
    lock_case;
    $display("test lock and low power done");
    wrap_up;
  end
endmodule : testbench

`default_nettype wire
